// >>> irb_pkg.sv
// Shared constants, types and helper functions of the indication and reply queue.
`default_nettype none
package irb_pkg;
    // Queue geometry: eight segments of 256 bytes in shared memory.
    localparam int          SEG_W      = 3;
    localparam logic [2:0]  SEG_MAX    = 3'h7;
    localparam int          OFF_W      = 8;
    localparam int          ADDR_W     = SEG_W + OFF_W;
    localparam int          MEM_W      = ADDR_W + 8;
    localparam int          SAP_N      = 64;
    // Indication block byte offsets.
    localparam logic [7:0]  OFF_STAT   = 8'h00;
    localparam logic [7:0]  OFF_CODE   = 8'h01;
    localparam logic [7:0]  OFF_REM    = 8'h06;
    localparam logic [7:0]  OFF_LOC    = 8'h07;
    localparam logic [7:0]  OFF_DATA   = 8'h08;
    // Field values.
    localparam logic [7:0]  NO_SAP     = 8'hff;
    localparam logic [7:0]  STAT_VALID = 8'h01;
    localparam logic [3:0]  CODE_DDB_LO = 4'h8;
    localparam logic [3:0]  CODE_DDB_HI = 4'ha;
    localparam logic [3:0]  RUP_HIGH   = 4'ha;
    // Bit positions in the control octet and reply status.
    localparam int          BIT_TOP    = 7;
    localparam int          BIT_FCB    = 5;
    localparam int          BIT_PRIO   = 1;
    localparam int          BIT_SINGLE = 4;

    // Frame classes as reported by the link layer.
    typedef enum logic [2:0] {
        K_SDN, K_SDA, K_SRD, K_SM, K_SMTIME, K_DDBREQ, K_DDBRSP
    } irb_kind_t;

    // Frames whose top control bit is meaningful.
    function automatic logic irb_is_request(input irb_kind_t k);
        return (k != K_DDBRSP) && (k != K_SM);
    endfunction : irb_is_request

    // Frames that are answered from a reply buffer.
    function automatic logic irb_needs_reply(input irb_kind_t k);
        return (k == K_SRD) || (k == K_DDBREQ);
    endfunction : irb_needs_reply

    // Frames that complete as soon as they are validated.
    function automatic logic irb_closes_now(input irb_kind_t k);
        return (k == K_SM) || (k == K_SMTIME) || (k == K_SDN) || (k == K_DDBRSP);
    endfunction : irb_closes_now
endpackage : irb_pkg
`default_nettype wire

// >>> irb_buf.sv
// Two-entry buffer that decouples memory writes from the frame stream.
`timescale 1ns/100ps
`default_nettype none
module irb_buf #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,   // System clock.
    input  wire logic         sys_rst,   // Synchronous reset, active high.
    input  wire logic         inValid,   // Writer offers a word.
    output logic              inReady,   // Room for a word.
    input  wire logic [W-1:0] inData,    // Offered word.
    output logic              outValid,  // Head word present.
    input  wire logic         outReady,  // Reader takes the head.
    output logic [W-1:0]      outData    // Head word, from a flop.
);
    logic [1:0]   cnt;   // Number of words held.
    logic [W-1:0] d1;    // Second entry.

    // Full and empty come straight from the count, so they never lie.
    assign inReady  = (cnt != 2'd2);
    assign outValid = (cnt != 2'd0);
    wire   push     = inValid && inReady;
    wire   pop      = outValid && outReady;

    // Count update; a pop and push together keep the level.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt <= 2'd0;
        end else if (push && !pop) begin
            cnt <= cnt + 2'd1;
        end else if (pop && !push) begin
            cnt <= cnt - 2'd1;
        end
    end

    // Data moves: head refills from the second entry or the input.
    always_ff @(posedge clk_sys) begin
        if (pop) begin
            if (cnt == 2'd2) begin
                d1 <= d1;
                outData <= d1;
            end else if (push) begin
                outData <= inData;
            end
        end else if (push) begin
            if (cnt == 2'd0) begin
                outData <= inData;
            end else begin
                d1 <= inData;
            end
        end
    end

    // A full buffer must refuse further words.
    property p_full_stall;
        @(posedge clk_sys) disable iff (sys_rst)
        (cnt == 2'd2 && !outReady) |=> !inReady;
    endproperty
    a_full_stall: assert property (p_full_stall) else $error("Full buffer accepted a word.");
    c_full: cover property (@(posedge clk_sys) cnt == 2'd2);
endmodule : irb_buf
`default_nettype wire

// >>> irb_reply.sv
// Reply buffer selection with single-update tracking per service point.
`timescale 1ns/100ps
`default_nettype none
module irb_reply
    import irb_pkg::*;
(
    input  wire logic       clk_sys,    // System clock.
    input  wire logic       sys_rst,    // Synchronous reset, active high.
    input  wire logic       fetch,      // Request needs reply data now.
    input  wire logic [5:0] fetchSap,   // Addressed local service point.
    input  wire logic [7:0] rupPtr,     // Reply pointer from the SAP entry.
    input  wire logic [7:0] rupStatus,  // Reply status byte.
    input  wire logic [7:0] rupLen,     // Reply length byte.
    input  wire logic       rearm,      // Host refilled a single-update buffer.
    input  wire logic [5:0] rearmSap,   // Service point being rearmed.
    output logic [7:0]      effLen,     // Length that will actually be sent.
    output logic            txStart,    // Reply send pulse.
    output logic [7:0]      txPtr,      // Buffer to send.
    output logic [7:0]      txLen,      // Bytes to send.
    output logic            txHigh      // Send with high priority.
);
    logic [SAP_N-1:0] used;  // Single-update buffer already sent.

    // The host must have filled the buffer before the request, so the
    // pointer is sampled the very cycle the request ends.
    wire statHigh = (rupStatus[3:0] == RUP_HIGH);
    assign effLen = used[fetchSap] ? 8'h00 : rupLen;

    // Send registers follow the fetch by one edge.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txStart <= 1'b0;
            txPtr   <= 8'h00;
            txLen   <= 8'h00;
            txHigh  <= 1'b0;
        end else begin
            txStart <= fetch;
            if (fetch) begin
                txPtr  <= rupPtr;
                txLen  <= effLen;
                txHigh <= statHigh;
            end
        end
    end

    // Sent-once marks; a send in the rearm cycle wins, so it stays marked.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            used <= '0;
        end else begin
            if (rearm) begin
                used[rearmSap] <= 1'b0;
            end
            if (fetch && rupStatus[BIT_SINGLE]) begin
                used[fetchSap] <= 1'b1;
            end
        end
    end

    property p_single;
        @(posedge clk_sys) disable iff (sys_rst)
        (fetch && used[fetchSap]) |=> txStart && txLen == 8'h00;
    endproperty
    a_single: assert property (p_single) else $error("Single reply sent twice.");
    property p_multi;
        @(posedge clk_sys) disable iff (sys_rst)
        (fetch && !rupStatus[BIT_SINGLE] && !used[fetchSap]) |=>
        txLen == $past(rupLen) && !used[$past(fetchSap)];
    endproperty
    a_multi: assert property (p_multi) else $error("Multiple reply not resent.");
    property p_prio;
        @(posedge clk_sys) disable iff (sys_rst)
        fetch |=> txStart && txHigh == $past(statHigh) && txPtr == $past(rupPtr);
    endproperty
    a_prio: assert property (p_prio) else $error("Reply priority or pointer wrong.");
    c_single: cover property (@(posedge clk_sys) fetch && used[fetchSap]);
endmodule : irb_reply
`default_nettype wire

// >>> irb_core.sv
// Indication queue writer and reply trigger for received fieldbus frames.
`timescale 1ns/100ps
`default_nettype none
module irb_core
    import irb_pkg::*;
(
    input  wire logic              clk_sys,    // System clock, 25 MHz.
    input  wire logic              sys_rst,    // Synchronous reset, active high.
    input  wire logic              frmStart,   // Frame header valid pulse.
    input  wire irb_kind_t         frmKind,    // Frame class.
    input  wire logic [7:0]        frmCtrl,    // Received control octet.
    input  wire logic              frmOther,   // Request addressed to another node.
    input  wire logic              frmSapExt,  // Address extension present.
    input  wire logic [7:0]        frmRemSap,  // Remote service point.
    input  wire logic [7:0]        frmLocSap,  // Local service point.
    input  wire logic              inValid,    // Net data byte offered.
    output logic                   inReady,    // Net data byte taken.
    input  wire logic [7:0]        inData,     // Net data byte.
    input  wire logic              frmEnd,     // Frame end, held until endAck.
    input  wire logic              frmOk,      // Frame error-free and validated.
    output logic                   endAck,     // Frame end taken.
    input  wire logic [7:0]        rupPtr,     // Reply pointer of sapSel.
    input  wire logic [7:0]        rupStatus,  // Reply status of that buffer.
    input  wire logic [7:0]        rupLen,     // Reply length of that buffer.
    output logic [5:0]             sapSel,     // Service point being looked up.
    input  wire logic              rearm,      // Host rearms a single reply.
    input  wire logic [5:0]        rearmSap,   // Service point rearmed.
    output logic                   txStart,    // Reply send pulse.
    output logic [7:0]             txPtr,      // Reply buffer pointer.
    output logic [7:0]             txLen,      // Reply byte count.
    output logic                   txHigh,     // Reply priority high.
    input  wire logic              txDone,     // Response went out.
    output logic                   memValid,   // Memory write offered.
    input  wire logic              memReady,   // Memory write accepted.
    output logic [ADDR_W-1:0]      memAddr,    // Memory byte address.
    output logic [7:0]             memData,    // Memory byte.
    output logic                   jobDone,    // Job-done interrupt pulse.
    output logic [SEG_W-1:0]       queueWp     // Queue write pointer.
);
    // Writer states.
    typedef enum logic [2:0] {
        S_IDLE, S_CLOSE, S_CODE, S_REM, S_LOC, S_DATA
    } irb_state_t;

    irb_state_t        state;       // Current state.
    irb_state_t        next_state;  // Next state.
    logic [SEG_W-1:0]  wp;          // Segment being filled.
    irb_kind_t         kind;        // Class of the captured frame.
    logic [7:0]        ctrl;        // Captured control octet.
    logic [7:0]        remSap;      // Captured remote service point.
    logic [7:0]        locSap;      // Captured local service point.
    logic [7:0]        dataCnt;     // Net data bytes written.
    logic              pend;        // SDA/SRD job awaiting the next request.
    logic              pendFcb;     // Frame count bit of the pending job.
    logic              respSent;    // Response of the pending job went out.
    logic              hdrNext;     // Start a new header after closing.
    logic [7:0]        effLen;      // Reply length after single-update check.
    logic              bufInReady;  // Buffer has room.
    logic [MEM_W-1:0]  bufOut;      // Buffer head word.

    // Function code: DDB responses use type 0, everything else type 1.
    wire       codeTop  = irb_is_request(kind) ? ctrl[BIT_TOP] : 1'b0;
    wire [3:0] ddbNib   = ctrl[BIT_PRIO] ? CODE_DDB_HI : CODE_DDB_LO;
    wire [7:0] codeByte = (kind == K_DDBRSP)
                        ? {2'b00, ctrl[BIT_FCB -: 2], ddbNib}
                        : {codeTop, 1'b1, ctrl[BIT_FCB -: 2], ctrl[3:0]};

    // Frame end handling and reply fetch.
    wire endTake  = (state == S_DATA) && frmEnd;
    wire needRep  = irb_needs_reply(kind);
    wire fetch    = endTake && frmOk && needRep;
    wire isNull   = needRep && (dataCnt == 8'h00) && (effLen == 8'h00);
    wire keepJob  = endTake && frmOk && !isNull;
    assign endAck = endTake;
    assign sapSel = locSap[5:0];

    // An answered pending job closes on a request elsewhere or with a toggled FCB.
    wire toggled  = (frmCtrl[BIT_FCB] != pendFcb);
    wire closeOld = pend && respSent && (frmOther || toggled);

    // Buffer input selection: header fields first, then net data.
    wire hdrState = (state == S_CLOSE) || (state == S_CODE) ||
                    (state == S_REM) || (state == S_LOC);
    wire bufInValid = hdrState || ((state == S_DATA) && inValid);
    wire [7:0] offSel = (state == S_CLOSE) ? OFF_STAT :
                        (state == S_CODE)  ? OFF_CODE :
                        (state == S_REM)   ? OFF_REM  :
                        (state == S_LOC)   ? OFF_LOC  :
                        8'(OFF_DATA + dataCnt);
    wire [7:0] byteSel = (state == S_CLOSE) ? STAT_VALID :
                         (state == S_CODE)  ? codeByte   :
                         (state == S_REM)   ? remSap     :
                         (state == S_LOC)   ? locSap     :
                         inData;
    wire bufStep  = bufInValid && bufInReady;
    wire closing  = (state == S_CLOSE) && bufInReady;
    wire dataStep = (state == S_DATA) && bufStep;
    // Net data is taken only while the buffer has room, so a stall loses no byte.
    assign inReady = (state == S_DATA) && bufInReady;
    // The eight segments form a ring.
    wire [SEG_W-1:0] wpInc = (wp == SEG_MAX) ? '0 : wp + 3'h1;

    // Next-state logic; header writes wait for buffer room.
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                // A waiting job is closed before the new header is written.
                if (frmStart && closeOld) begin
                    next_state = S_CLOSE;
                end else if (frmStart && !frmOther) begin
                    next_state = S_CODE;
                end
            end
            S_CLOSE: begin
                // Status written; go on to the new header if one is waiting.
                if (bufInReady) begin
                    next_state = hdrNext ? S_CODE : S_IDLE;
                end
            end
            S_CODE: begin
                // Header bytes follow one per free buffer slot.
                if (bufInReady) begin
                    next_state = S_REM;
                end
            end
            S_REM: begin
                if (bufInReady) begin
                    next_state = S_LOC;
                end
            end
            S_LOC: begin
                if (bufInReady) begin
                    next_state = S_DATA;
                end
            end
            S_DATA: begin
                if (endTake) begin
                    // Validated SM, SDN and DDB responses close at once.
                    next_state = (keepJob && irb_closes_now(kind)) ? S_CLOSE : S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // State register and completion bookkeeping.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state   <= S_IDLE;
            wp      <= '0;
            jobDone <= 1'b0;
        end else begin
            state   <= next_state;
            jobDone <= closing;
            if (closing) begin
                wp <= wpInc;
            end
        end
    end

    // Header capture; frames without extension get the no-SAP marker.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            kind    <= K_SDN;
            ctrl    <= 8'h00;
            remSap  <= NO_SAP;
            locSap  <= NO_SAP;
            hdrNext <= 1'b0;
        end else if (state == S_IDLE && frmStart) begin
            hdrNext <= !frmOther;
            if (!frmOther) begin
                kind   <= frmKind;
                ctrl   <= frmCtrl;
                remSap <= frmSapExt ? frmRemSap : NO_SAP;
                locSap <= frmSapExt ? frmLocSap : NO_SAP;
            end
        end else if (endTake) begin
            hdrNext <= 1'b0;
        end
    end

    // Net data counter restarts with every header.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state == S_CODE) begin
            dataCnt <= 8'h00;
        end else if (dataStep) begin
            dataCnt <= dataCnt + 8'h01;
        end
    end

    // Pending SDA/SRD job. A retry of the same frame drops it, so the
    // repeated frame simply rewrites the same segment.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend     <= 1'b0;
            pendFcb  <= 1'b0;
            respSent <= 1'b0;
        end else if (keepJob && !irb_closes_now(kind)) begin
            pend     <= 1'b1;
            pendFcb  <= ctrl[BIT_FCB];
            respSent <= 1'b0;
        end else if ((state == S_IDLE && frmStart && !closeOld) || closing) begin
            pend     <= 1'b0;
            respSent <= 1'b0;
        end else if (txDone && pend) begin
            respSent <= 1'b1;
        end
    end

    // Write path to shared memory; a stalled memory stalls the frame.
    irb_buf #(.W(MEM_W)) uBuf (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .inValid  (bufInValid),
        .inReady  (bufInReady),
        .inData   ({wp, offSel, byteSel}),
        .outValid (memValid),
        .outReady (memReady),
        .outData  (bufOut)
    );
    // The head word splits into byte address and data byte.
    assign memAddr = bufOut[MEM_W-1:8];
    assign memData = bufOut[7:0];
    assign queueWp = wp;

    // Reply lookup and send trigger.
    irb_reply uReply (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .fetch     (fetch),
        .fetchSap  (sapSel),
        .rupPtr    (rupPtr),
        .rupStatus (rupStatus),
        .rupLen    (rupLen),
        .rearm     (rearm),
        .rearmSap  (rearmSap),
        .effLen    (effLen),
        .txStart   (txStart),
        .txPtr     (txPtr),
        .txLen     (txLen),
        .txHigh    (txHigh)
    );

    // Function code checks, one per coding rule.
    property p_ddb_code;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == S_CODE && kind == K_DDBRSP) |->
        codeByte[6] == 1'b0 && codeByte[3:0] == (ctrl[BIT_PRIO] ? CODE_DDB_HI : CODE_DDB_LO);
    endproperty
    a_ddb_code: assert property (p_ddb_code) else $error("DDB response code wrong.");
    property p_req_code;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == S_CODE && kind != K_DDBRSP) |-> codeByte[6] && codeByte[5:4] == ctrl[5:4];
    endproperty
    a_req_code: assert property (p_req_code) else $error("Request code wrong.");
    property p_top_bit;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == S_CODE && (kind == K_SM || kind == K_DDBRSP)) |-> !codeByte[7];
    endproperty
    a_top_bit: assert property (p_top_bit) else $error("Top bit leaked.");
    // Without an extension both service points carry the marker.
    property p_rem_sap;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == S_IDLE && frmStart && !frmOther && !frmSapExt) |=> remSap == NO_SAP;
    endproperty
    a_rem_sap: assert property (p_rem_sap) else $error("Remote SAP not 0FFh.");
    property p_loc_sap;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == S_IDLE && frmStart && !frmOther && !frmSapExt) |=> ##3 locSap == NO_SAP;
    endproperty
    a_loc_sap: assert property (p_loc_sap) else $error("Local SAP not 0FFh.");
    // Completion, immediate closing and empty polling.
    property p_close;
        @(posedge clk_sys) disable iff (sys_rst)
        closing |=> jobDone && wp == ($past(wp) == SEG_MAX ? 3'h0 : $past(wp) + 3'h1);
    endproperty
    a_close: assert property (p_close) else $error("Completion did not advance.");
    property p_now;
        @(posedge clk_sys) disable iff (sys_rst)
        (endTake && frmOk && irb_closes_now(kind)) |=> state == S_CLOSE;
    endproperty
    a_now: assert property (p_now) else $error("Validated frame not closed.");
    property p_empty;
        @(posedge clk_sys) disable iff (sys_rst)
        (endTake && frmOk && isNull && !pend) |=> state == S_IDLE && !pend ##1 !jobDone;
    endproperty
    a_empty: assert property (p_empty) else $error("Empty poll was queued.");
    property p_srd_wait;
        @(posedge clk_sys) disable iff (sys_rst)
        (endTake && frmOk && !isNull && kind == K_SRD) |=> pend && !respSent && !jobDone;
    endproperty
    a_srd_wait: assert property (p_srd_wait) else $error("SRD closed too early.");
    // A request for another node closes an answered pending job.
    property p_other_close;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == S_IDLE && frmStart && frmOther && pend && respSent) |=> state == S_CLOSE;
    endproperty
    a_other_close: assert property (p_other_close) else $error("Job not closed.");
    // A frame that failed its checks is dropped without an indication.
    property p_bad_frame;
        @(posedge clk_sys) disable iff (sys_rst)
        (endTake && !frmOk) |=> state == S_IDLE ##1 !jobDone;
    endproperty
    a_bad_frame: assert property (p_bad_frame) else $error("Bad frame indicated.");
    // Covers for the deferred close, the ring wrap and a memory stall.
    c_close_old: cover property (@(posedge clk_sys) state == S_IDLE && frmStart && closeOld);
    c_wrap: cover property (@(posedge clk_sys) closing && wp == SEG_MAX);
    c_stall: cover property (@(posedge clk_sys) state == S_DATA && inValid && !bufInReady);
endmodule : irb_core
`default_nettype wire

// >>> irb_far.sv
// Far-side model: shared memory that stalls, host reply table, send done.
`timescale 1ns/100ps
`default_nettype none
module irb_far
    import irb_pkg::*;
(
    input  wire logic              clk_sys,   // System clock.
    input  wire logic              memValid,  // Write offered.
    output logic                   memReady,  // Toggles, so the buffer must hold words.
    input  wire logic [ADDR_W-1:0] memAddr,   // Byte address.
    input  wire logic [7:0]        memData,   // Byte.
    input  wire logic [5:0]        sapSel,    // Looked-up service point.
    output logic [7:0]             rupPtr,    // Reply pointer.
    output logic [7:0]             rupStatus, // Reply status.
    output logic [7:0]             rupLen,    // Reply length.
    input  wire logic              txStart,   // Send pulse.
    output logic                   txDone     // Send finished.
);
    logic [7:0] mem [0:2047]; // Shared memory image.
    logic       sent;         // Send in flight.
    initial {memReady, sent, txDone} = 3'h0;
    // Filled before any request: SAP 1 single-update high, SAP 3 empty.
    assign rupPtr    = {2'h1, sapSel};
    assign rupStatus = (sapSel == 6'h01) ? 8'h1a : 8'h08;
    assign rupLen    = (sapSel == 6'h03) ? 8'h00 : 8'h04;
    // Stalling every other cycle is harsher than a real memory port.
    always @(posedge clk_sys) begin
        memReady <= ~memReady;
        sent     <= txStart;
        txDone   <= sent;
        if (memValid && memReady) begin
            mem[memAddr] <= memData;
        end
    end
endmodule : irb_far
`default_nettype wire

// >>> indication_reply_queue_test.sv
// Self-checking bench for the indication and reply queue core.
`timescale 1ns/100ps
`default_nettype none
module indication_reply_queue_test;
    import irb_pkg::*;
    logic              clk_sys, sys_rst, frmStart, frmSapExt, inValid, frmEnd, seenHi;
    logic              frmOther, frmOk;                                // Link qualifiers.
    irb_kind_t         frmKind;                                        // Frame class.
    logic [7:0]        frmCtrl, frmLocSap, inData, txPtr, txLen, seenLen;
    logic              inReady, endAck, txStart, txHigh, txDone, memValid, memReady, jobDone;
    logic [7:0]        rupPtr, rupStatus, rupLen, memData;             // Reply and memory.
    logic [5:0]        sapSel;                                         // Looked-up SAP.
    logic [ADDR_W-1:0] memAddr;                                        // Memory address.
    logic [SEG_W-1:0]  queueWp;                                        // Queue pointer.
    int                n_fail, n_checks, cyc, jobs;                    // Counters.
    // Frame table: kind, control octet, local SAP, byte count, expected pointer, reply length.
    // Frame 7 is addressed to another node, frame 8 fails its checks.
    irb_kind_t  kd [11] = '{K_SDN, K_DDBRSP, K_SRD, K_SRD, K_SRD, K_SRD, K_SRD, K_SDN, K_SDN,
                            K_SDN, K_SDN};
    logic [7:0] ct [11] = '{8'h00, 8'h02, 8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h00,
                            8'h00, 8'h20};
    logic [7:0] lc [11] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h02, 8'h02, 8'h01, 8'h01,
                            8'h01, 8'h01};
    int         nb [11] = '{2, 1, 1, 1, 0, 1, 1, 0, 1, 1, 1};
    logic [7:0] wp [11] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h04, 8'h04, 8'h05, 8'h06, 8'h06,
                            8'h07, 8'h00};
    logic [7:0] ln [11] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00,
                            8'h00, 8'h00};
    irb_core dut (.*, .frmRemSap(8'h12), .rearm(1'b0), .rearmSap(6'h00));
    irb_far p (.*);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // Catch each reply launch and cut a hang short.
    always @(posedge clk_sys) begin
        cyc++;
        if (jobDone === 1'b1) jobs++;
        if (txStart === 1'b1) {seenLen, seenHi} = {txLen, txHigh};
        if (cyc == 4000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        {sys_rst, frmStart, frmSapExt, inValid, frmEnd} = 5'h10;
        {frmCtrl, frmLocSap, inData} = 24'h0;
        {frmOther, frmOk} = 2'h0;
        frmKind = K_SDN;
        {n_fail, n_checks, cyc, jobs} = '0;
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int i = 0; i < 11; i++) begin
            seenLen = 8'hff;
            frmKind = kd[i];
            {frmStart, frmCtrl, frmLocSap, frmSapExt} = {1'b1, ct[i], lc[i], i != 1};
            {frmOther, frmOk} = {i == 7, i != 8};
            @(negedge clk_sys) frmStart = 1'b0;
            repeat (3) @(negedge clk_sys);
            for (int b = 0; b < nb[i]; b++) begin
                {inValid, inData} = {1'b1, 8'h30 + 8'(b)};
                do @(posedge clk_sys); while (!inReady);
                @(negedge clk_sys);
            end
            inValid = 1'b0;
            if (i != 7) begin
                frmEnd = 1'b1;
                do @(posedge clk_sys); while (!endAck);
                @(negedge clk_sys) frmEnd = 1'b0;
            end
            repeat (30) @(negedge clk_sys);
            chk(8'(queueWp), wp[i]);
            if (kd[i] == K_SRD && i != 4) begin
                chk(seenLen, ln[i]);
                chk(8'(seenHi), 8'(lc[i] == 8'h01));
            end
        end
        chk(p.mem[0], STAT_VALID);
        chk(p.mem[1] & 8'h60, 8'h40);
        chk(p.mem[513] & 8'h60, 8'h60);
        chk(p.mem[257] & 8'h4f, 8'h0a);
        chk(p.mem[6], 8'h12);
        chk(p.mem[262], NO_SAP);
        chk(p.mem[7], 8'h01);
        chk(p.mem[263], NO_SAP);
        chk(p.mem[8], 8'h30);
        chk(p.mem[9], 8'h31);
        chk(p.mem[512], STAT_VALID);
        chk(8'(jobs), 8'h08);
        chk(txPtr, 8'h42);
        finish_test();
    end
endmodule : indication_reply_queue_test
`default_nettype wire
